// ### rtl/acc_flags_program_counter.sv
`timescale 1ns/1ns
module acc_flags_program_counter #(
  parameter int PC_W = 10,
  parameter int ADR_W = 10
) (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Instruction port from the sequencer
  input wire logic i_op_valid,
  input wire core_pkg::op_t i_op,
  input wire core_pkg::dest_t i_op_dest,
  input wire logic [7:0] i_op_operand,
  input wire logic [PC_W-1:0] i_op_target,
  input wire logic [2:0] i_op_bit_sel,
  // Supply detector and reset source, asynchronous
  input wire logic i_lv_high_det,
  input wire logic i_lv_mid_det,
  input wire logic [1:0] i_reset_cause,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Core state
  output logic [PC_W-1:0] o_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_flags,
  output logic [7:0] o_mem_data,
  output logic o_mem_we,
  output logic o_skip
);
  localparam int PH_W = PC_W - 8;

  generate
    if (PC_W < 9 || PC_W > 16) begin : g_bad_pc
      $error("PC_W must be 9 to 16");
    end
    if (ADR_W < 10) begin : g_bad_adr
      $error("ADR_W must be at least 10");
    end
  endgenerate

  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [7:0] accumulator_reg;
  logic [7:0] status_flag_reg;
  logic [1:0] option_reg;
  logic [3:0] det_meta;
  logic [3:0] det_sync;
  logic [1:0] cause_cnt;
  logic cause_load;
  logic fire;
  logic push_fire;
  logic pop_fire;
  logic is_jump;
  logic add_family;
  logic pcl_wr;
  logic acc_wr;
  logic mem_wr;
  logic [7:0] alu_x;
  logic [7:0] alu_y;
  logic [7:0] alu_res;
  logic alu_carry;
  logic alu_half;
  logic alu_zero;
  logic alu_wr_c;
  logic alu_wr_dc;
  logic alu_wr_z;
  logic alu_wr_dest;
  logic alu_skip;
  logic [7:0] saved_acc;
  logic [7:0] saved_flags;
  logic wb_req;
  logic hit_flags;
  logic hit_pc;
  logic hit_opt;
  logic wr_flags;
  logic wr_pc;
  logic wr_opt;
  logic [31:0] rd_mux;

  assign o_pc = pc;
  assign o_acc = accumulator_reg;
  assign o_flags = status_flag_reg;

  assign fire = i_op_valid & i_clk_en;
  assign push_fire = fire & (i_op == core_pkg::push_op);
  assign pop_fire = fire & (i_op == core_pkg::pop_op);
  assign is_jump = (i_op == core_pkg::jump_op) || (i_op == core_pkg::call_op) ||
                   (i_op == core_pkg::interrupt_entry_op) ||
                   (i_op == core_pkg::interrupt_return_op);
  assign add_family = (i_op == core_pkg::add_op) || (i_op == core_pkg::add_carry_op) ||
                      (i_op == core_pkg::bank0_add_op);
  assign pcl_wr = alu_wr_dest & (i_op_dest == core_pkg::dest_pcl);
  assign acc_wr = (alu_wr_dest & (i_op_dest == core_pkg::dest_acc)) ||
                  (i_op == core_pkg::increment_to_acc_skip_op) ||
                  (i_op == core_pkg::decrement_to_acc_skip_op);
  assign mem_wr = (alu_wr_dest & (i_op_dest == core_pkg::dest_mem)) ||
                  (i_op == core_pkg::increment_mem_skip_op) ||
                  (i_op == core_pkg::decrement_mem_skip_op);

  // Destination is the left operand, so subtracts run dest minus source
  always_comb begin
    if (i_op_dest == core_pkg::dest_pcl) begin
      alu_x = pc[7:0];
      alu_y = accumulator_reg;
    end else if (i_op_dest == core_pkg::dest_mem) begin
      alu_x = i_op_operand;
      alu_y = accumulator_reg;
    end else begin
      alu_x = accumulator_reg;
      alu_y = i_op_operand;
    end
  end

  alu_unit u_alu (
    .i_op(i_op),
    .i_x(alu_x),
    .i_y(alu_y),
    .i_acc(accumulator_reg),
    .i_operand(i_op_operand),
    .i_bit_sel(i_op_bit_sel),
    .i_carry(status_flag_reg[core_pkg::CARRY_BIT]),
    .o_result(alu_res),
    .o_carry(alu_carry),
    .o_half(alu_half),
    .o_zero(alu_zero),
    .o_wr_c(alu_wr_c),
    .o_wr_dc(alu_wr_dc),
    .o_wr_z(alu_wr_z),
    .o_wr_dest(alu_wr_dest),
    .o_skip(alu_skip)
  );

  flag_save_buf u_save (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_store(push_fire),
    .i_acc(accumulator_reg),
    .i_flags(status_flag_reg),
    .o_acc(saved_acc),
    .o_flags(saved_flags)
  );

  // Detector levels and reset source cross in through two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      det_meta <= 4'h0;
      det_sync <= 4'h0;
    end else if (i_clk_en) begin
      det_meta <= {i_reset_cause, i_lv_mid_det, i_lv_high_det};
      det_sync <= det_meta;
    end
  end

  // Cause is caught once the synchroniser has filled after release
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cause_cnt <= 2'h0;
    end else if (i_clk_en && cause_cnt != 2'h3) begin
      cause_cnt <= cause_cnt + 2'h1;
    end
  end
  assign cause_load = i_clk_en & (cause_cnt == core_pkg::CAUSE_LOAD_AT);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      option_reg <= core_pkg::OPTION_RST;
    end else if (wr_opt && i_wb_sel[0]) begin
      option_reg <= i_wb_dat[1:0];
    end
  end

  // Instruction updates win over a bus write landing in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_flag_reg <= core_pkg::FLAGS_RST;
    end else if (i_clk_en) begin
      status_flag_reg[core_pkg::LV_HIGH_BIT] <=
        det_sync[0] & option_reg[core_pkg::OPT_HIGH_BIT];
      status_flag_reg[core_pkg::LV_MID_BIT] <=
        det_sync[1] & option_reg[core_pkg::OPT_MID_BIT];
      status_flag_reg[3] <= 1'b0;
      if (cause_load) begin
        status_flag_reg[7:6] <= det_sync[3:2];
      end else if (pop_fire) begin
        status_flag_reg[7:6] <= saved_flags[7:6];
      end else if (wr_flags && i_wb_sel[0]) begin
        status_flag_reg[7:6] <= i_wb_dat[7:6];
      end
      if (pop_fire) begin
        status_flag_reg[2:0] <= saved_flags[2:0];
      end else begin
        if (wr_flags && i_wb_sel[0]) begin
          status_flag_reg[2:0] <= i_wb_dat[2:0];
        end
        if (fire && alu_wr_c) begin
          status_flag_reg[core_pkg::CARRY_BIT] <= alu_carry;
        end
        if (fire && alu_wr_dc) begin
          status_flag_reg[core_pkg::HALF_BIT] <= alu_half;
        end
        if (fire && alu_wr_z) begin
          status_flag_reg[core_pkg::ZERO_BIT] <= alu_zero;
        end
      end
    end
  end

  // Interrupt entry only redirects the counter here
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      accumulator_reg <= 8'h00;
    end else if (pop_fire) begin
      accumulator_reg <= saved_acc;
    end else if (fire && acc_wr) begin
      accumulator_reg <= alu_res;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_we <= 1'b0;
      o_mem_data <= 8'h00;
      o_skip <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_we <= fire & mem_wr;
      o_skip <= fire & alu_skip & ~is_jump;
      if (fire && mem_wr) begin
        o_mem_data <= alu_res;
      end
    end
  end

  always_comb begin
    next_pc = pc;
    if (wr_pc && i_wb_sel[0]) begin
      next_pc[7:0] = i_wb_dat[7:0];
    end
    if (wr_pc && i_wb_sel[1]) begin
      next_pc[PC_W-1:8] = i_wb_dat[PC_W-1:8];
    end
    if (fire) begin
      if (is_jump) begin
        next_pc = i_op_target;
      end else if (pcl_wr) begin
        next_pc[7:0] = alu_res;
        next_pc[PC_W-1:8] = pc[PC_W-1:8];
        if (add_family && alu_carry) begin
          next_pc[PC_W-1:8] = pc[PC_W-1:8] + PH_W'(1);
        end
      end else if (alu_skip) begin
        next_pc = pc + PC_W'(core_pkg::SKIP_STEP);
      end else begin
        next_pc = pc + PC_W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc <= '0;
    end else if (i_clk_en) begin
      pc <= next_pc;
    end
  end

  // Wishbone slave, one wait state; unmapped reads return zero
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack & i_clk_en;
  assign hit_flags = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(core_pkg::FLAGS_IDX));
  assign hit_pc = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(core_pkg::PC_WORD_IDX));
  assign hit_opt = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(core_pkg::OPTION_IDX));
  assign wr_flags = wb_req & i_wb_we & hit_flags;
  assign wr_pc = wb_req & i_wb_we & hit_pc;
  assign wr_opt = wb_req & i_wb_we & hit_opt;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_flags) begin
      rd_mux[7:0] = status_flag_reg;
    end else if (hit_pc) begin
      rd_mux[PC_W-1:0] = pc;
    end else if (hit_opt) begin
      rd_mux[1:0] = option_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_pop_fire;
    fire && i_op == core_pkg::pop_op;
  endsequence

  sequence s_pcl_add_carry;
    fire && pcl_wr && add_family && alu_carry;
  endsequence

  chk_jump_load: assert property (
    fire && (i_op == core_pkg::jump_op || i_op == core_pkg::call_op)
    |=> pc == $past(i_op_target))
    else $error("jump target not loaded");
  chk_plain_step: assert property (
    fire && i_op == core_pkg::nop_op |=> pc == $past(pc) + PC_W'(1))
    else $error("counter did not step by one");
  chk_skip_step: assert property (
    fire && alu_skip && !is_jump && !pcl_wr
    |=> pc == $past(pc) + PC_W'(2) ##0 o_skip)
    else $error("skip did not advance by two");
  chk_pch_carry: assert property (
    s_pcl_add_carry |=> pc[PC_W-1:8] == $past(pc[PC_W-1:8]) + PH_W'(1))
    else $error("high part missed low byte carry");
  chk_pch_sub_hold: assert property (
    fire && pcl_wr && i_op == core_pkg::sub_op
    |=> $stable(pc[PC_W-1:8]) && pc[7:0] == $past(alu_res))
    else $error("subtract moved high part");
  chk_int_no_save: assert property (
    fire && i_op == core_pkg::interrupt_entry_op
    |=> $stable(accumulator_reg) && $stable(status_flag_reg[2:0]))
    else $error("interrupt entry changed acc or flags");
  chk_pop_restore: assert property (
    s_pop_fire |=> accumulator_reg == $past(saved_acc) &&
    status_flag_reg[2:0] == $past(saved_flags[2:0]))
    else $error("pop did not restore");
  chk_bank0_no_acc: assert property (
    fire && i_op == core_pkg::bank0_move_op && i_op_dest == core_pkg::dest_mem
    |=> $stable(accumulator_reg) ##1 1'b1)
    else $error("bank0 move reached accumulator");
  chk_lv_high: assert property (
    i_clk_en |=> status_flag_reg[core_pkg::LV_HIGH_BIT] ==
    ($past(det_sync[0]) & $past(option_reg[core_pkg::OPT_HIGH_BIT])))
    else $error("high low-volt flag wrong");
  chk_zero_flag: assert property (
    fire && alu_wr_z && !pop_fire
    |=> status_flag_reg[core_pkg::ZERO_BIT] == $past(alu_zero))
    else $error("zero flag wrong");
  chk_unused_bit: assert property (
    status_flag_reg[3] == 1'b0)
    else $error("unused flag bit set");
  chk_cmp_skip: assert property (
    fire && i_op == core_pkg::compare_skip_op && accumulator_reg == i_op_operand
    |=> o_skip)
    else $error("compare equal did not skip");
endmodule : acc_flags_program_counter

// ### rtl/core_pkg.sv
package core_pkg;
  typedef enum logic [4:0] {
    nop_op = 5'h00,
    move_op = 5'h01,
    bank0_move_op = 5'h02,
    add_op = 5'h03,
    add_carry_op = 5'h04,
    bank0_add_op = 5'h05,
    sub_op = 5'h06,
    and_op = 5'h07,
    or_op = 5'h08,
    xor_op = 5'h09,
    rot_left_op = 5'h0A,
    rot_right_op = 5'h0B,
    compare_skip_op = 5'h0C,
    increment_to_acc_skip_op = 5'h0D,
    increment_mem_skip_op = 5'h0E,
    decrement_to_acc_skip_op = 5'h0F,
    decrement_mem_skip_op = 5'h10,
    bit_clear_skip_op = 5'h11,
    bit_set_skip_op = 5'h12,
    bank0_bit_clear_skip_op = 5'h13,
    bank0_bit_set_skip_op = 5'h14,
    jump_op = 5'h15,
    call_op = 5'h16,
    interrupt_entry_op = 5'h17,
    interrupt_return_op = 5'h18,
    push_op = 5'h19,
    pop_op = 5'h1A
  } op_t;

  typedef enum logic [1:0] {
    dest_acc = 2'h0,
    dest_mem = 2'h1,
    dest_pcl = 2'h2
  } dest_t;

  // Register indices; byte address is four times the index
  localparam logic [7:0] FLAGS_IDX = 8'h86;
  localparam logic [7:0] PC_WORD_IDX = 8'h88;
  localparam logic [7:0] OPTION_IDX = 8'h89;

  localparam int CAUSE_HI_BIT = 7;
  localparam int CAUSE_LO_BIT = 6;
  localparam int LV_HIGH_BIT = 5;
  localparam int LV_MID_BIT = 4;
  localparam int CARRY_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int ZERO_BIT = 0;
  localparam int OPT_HIGH_BIT = 0;
  localparam int OPT_MID_BIT = 1;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [1:0] OPTION_RST = 2'h0;
  localparam logic [1:0] CAUSE_LOAD_AT = 2'h2;
  localparam int SKIP_STEP = 2;
endpackage : core_pkg

// ### rtl/alu_unit.sv
`timescale 1ns/1ns
module alu_unit (
  // Operation
  input wire core_pkg::op_t i_op,
  input wire logic [7:0] i_x,
  input wire logic [7:0] i_y,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_carry,
  // Results
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_half,
  output logic o_zero,
  output logic o_wr_c,
  output logic o_wr_dc,
  output logic o_wr_z,
  output logic o_wr_dest,
  output logic o_skip
);
  always_comb begin
    logic [8:0] wide;
    logic [4:0] nib;
    logic cin;
    wide = 9'h000;
    nib = 5'h00;
    cin = 1'b0;
    o_result = i_x;
    o_carry = i_carry;
    o_half = 1'b0;
    o_wr_c = 1'b0;
    o_wr_dc = 1'b0;
    o_wr_z = 1'b0;
    o_wr_dest = 1'b0;
    o_skip = 1'b0;
    case (i_op)
      core_pkg::move_op, core_pkg::bank0_move_op: begin
        o_result = i_y;
        o_wr_dest = 1'b1;
      end
      core_pkg::add_op, core_pkg::add_carry_op, core_pkg::bank0_add_op: begin
        cin = (i_op == core_pkg::add_carry_op) & i_carry;
        wide = {1'b0, i_x} + {1'b0, i_y} + {8'h00, cin};
        nib = {1'b0, i_x[3:0]} + {1'b0, i_y[3:0]} + {4'h0, cin};
        o_result = wide[7:0];
        o_carry = wide[8];
        o_half = nib[4];
        {o_wr_c, o_wr_dc, o_wr_z, o_wr_dest} = 4'hF;
      end
      core_pkg::sub_op: begin
        wide = {1'b0, i_x} - {1'b0, i_y};
        nib = {1'b0, i_x[3:0]} - {1'b0, i_y[3:0]};
        o_result = wide[7:0];
        o_carry = ~wide[8];
        o_half = ~nib[4];
        {o_wr_c, o_wr_dc, o_wr_z, o_wr_dest} = 4'hF;
      end
      core_pkg::and_op, core_pkg::or_op, core_pkg::xor_op: begin
        if (i_op == core_pkg::and_op) begin
          o_result = i_x & i_y;
        end else if (i_op == core_pkg::or_op) begin
          o_result = i_x | i_y;
        end else begin
          o_result = i_x ^ i_y;
        end
        o_wr_z = 1'b1;
        o_wr_dest = 1'b1;
      end
      core_pkg::rot_left_op: begin
        o_result = {i_x[6:0], i_carry};
        o_carry = i_x[7];
        o_wr_c = 1'b1;
        o_wr_dest = 1'b1;
      end
      core_pkg::rot_right_op: begin
        o_result = {i_carry, i_x[7:1]};
        o_carry = i_x[0];
        o_wr_c = 1'b1;
        o_wr_dest = 1'b1;
      end
      core_pkg::compare_skip_op: begin
        wide = {1'b0, i_acc} - {1'b0, i_operand};
        o_carry = ~wide[8];
        o_skip = (wide[7:0] == 8'h00);
        o_wr_c = 1'b1;
        o_wr_z = 1'b1;
      end
      core_pkg::increment_to_acc_skip_op, core_pkg::increment_mem_skip_op: begin
        o_result = i_operand + 8'h01;
        o_skip = (i_operand == 8'hFF);
      end
      core_pkg::decrement_to_acc_skip_op, core_pkg::decrement_mem_skip_op: begin
        o_result = i_operand - 8'h01;
        o_skip = (i_operand == 8'h01);
      end
      core_pkg::bit_clear_skip_op, core_pkg::bank0_bit_clear_skip_op: begin
        o_skip = ~i_operand[i_bit_sel];
      end
      core_pkg::bit_set_skip_op, core_pkg::bank0_bit_set_skip_op: begin
        o_skip = i_operand[i_bit_sel];
      end
      default: begin
        o_result = i_x;
      end
    endcase
    if (i_op == core_pkg::compare_skip_op) begin
      o_zero = (wide[7:0] == 8'h00);
    end else begin
      o_zero = (o_result == 8'h00);
    end
  end
endmodule : alu_unit

// ### rtl/flag_save_buf.sv
`timescale 1ns/1ns
module flag_save_buf (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Save port
  input wire logic i_store,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_flags,
  // Saved values
  output logic [7:0] o_acc,
  output logic [7:0] o_flags
);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_acc <= 8'h00;
      o_flags <= 8'h00;
    end else if (i_clk_en && i_store) begin
      o_acc <= i_acc;
      o_flags <= i_flags;
    end
  end
endmodule : flag_save_buf

// ### verification/acc_flags_program_counter_test.sv
`timescale 1ns/1ns
module acc_flags_program_counter_test;
  logic i_sys_clk;
  logic i_rst_b;
  logic i_clk_en;
  logic i_op_valid;
  core_pkg::op_t i_op;
  core_pkg::dest_t i_op_dest;
  logic [7:0] i_op_operand;
  logic [9:0] i_op_target;
  logic [2:0] i_op_bit_sel;
  logic i_lv_high_det;
  logic i_lv_mid_det;
  logic [1:0] i_reset_cause;
  logic i_wb_cyc;
  logic i_wb_stb;
  logic i_wb_we;
  logic [9:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic [9:0] o_pc;
  logic [7:0] o_acc;
  logic [7:0] o_flags;
  logic [7:0] o_mem_data;
  logic o_mem_we;
  logic o_skip;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic [9:0] p;
  logic [7:0] fl;

  acc_flags_program_counter #(.PC_W(10), .ADR_W(10)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_op_dest(i_op_dest),
    .i_op_operand(i_op_operand), .i_op_target(i_op_target), .i_op_bit_sel(i_op_bit_sel),
    .i_lv_high_det(i_lv_high_det), .i_lv_mid_det(i_lv_mid_det),
    .i_reset_cause(i_reset_cause), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_pc(o_pc), .o_acc(o_acc),
    .o_flags(o_flags), .o_mem_data(o_mem_data), .o_mem_we(o_mem_we), .o_skip(o_skip)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_op(input core_pkg::op_t op, input core_pkg::dest_t d,
      input logic [7:0] v, input logic [9:0] t, input logic [2:0] b);
    @(posedge i_sys_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_op_dest <= d;
    i_op_operand <= v;
    i_op_target <= t;
    i_op_bit_sel <= b;
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask : do_op

  task automatic mv(input core_pkg::dest_t d, input logic [7:0] v);
    do_op(core_pkg::move_op, d, v, 10'h000, 3'h0);
  endtask : mv

  task automatic do_skip(input core_pkg::op_t op, input logic [7:0] v, input logic [2:0] b,
      input logic exp);
    logic [9:0] pc0;
    mv(core_pkg::dest_acc, 8'h12);
    pc0 = o_pc;
    do_op(op, core_pkg::dest_acc, v, 10'h000, b);
    chk("skip", o_skip, exp);
    chk("skip_pc", o_pc, exp ? pc0 + 10'h002 : pc0 + 10'h001);
  endtask : do_skip

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd);
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_sys_clk);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    #1;
  endtask : wb

  // Mid-run reset with a chosen cause code
  task automatic rst_cycle(input logic [1:0] c);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    i_reset_cause <= c;
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk("cause_again", o_flags[7:6], c);
    chk("pc_again", o_pc, 32'h0000_0000);
  endtask : rst_cycle

  initial begin
    repeat (3000) @(posedge i_sys_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    i_rst_b = 1'b0;
    i_clk_en = 1'b1;
    i_op_valid = 1'b0;
    i_op = core_pkg::nop_op;
    i_op_dest = core_pkg::dest_acc;
    i_op_operand = 8'h00;
    i_op_target = 10'h000;
    i_op_bit_sel = 3'h0;
    i_lv_high_det = 1'b1;
    i_lv_mid_det = 1'b1;
    i_reset_cause = 2'h3;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 10'h000;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0000_0000;
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    #1;
    chk("pc_rst", o_pc, 32'h0000_0000);
    chk("flags_rst", o_flags, 32'h0000_0000);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk("cause", o_flags[7:6], 32'h0000_0003);
    chk("lv_no_opt", o_flags[5:4], 32'h0000_0000);
    $display("test reset done");

    wb(1'b1, 10'h224, 32'h0000_0003, 4'h1, q);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk("lv_both", o_flags[5:4], 32'h0000_0003);
    i_lv_mid_det <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk("lv_high", o_flags[5:4], 32'h0000_0002);
    wb(1'b1, 10'h218, 32'h0000_00FF, 4'h1, q);
    wb(1'b0, 10'h218, 32'h0000_0000, 4'h1, q);
    chk("flags_ff", q[7:0], 32'h0000_00E7);
    wb(1'b1, 10'h218, 32'h0000_0000, 4'h1, q);
    chk("flags_00", o_flags, 32'h0000_0020);
    wb(1'b1, 10'h220, 32'h0000_0155, 4'h3, q);
    wb(1'b0, 10'h220, 32'h0000_0000, 4'h3, q);
    chk("pc_word", q[9:0], 32'h0000_0155);
    wb(1'b0, 10'h3F0, 32'h0000_0000, 4'hF, q);
    chk("unmapped", q, 32'h0000_0000);
    $display("test registers done");

    mv(core_pkg::dest_acc, 8'hFF);
    p = o_pc;
    do_op(core_pkg::add_op, core_pkg::dest_acc, 8'h01, 10'h000, 3'h0);
    chk("acc_add", o_acc, 32'h0000_0000);
    chk("flags_add", o_flags[2:0], 32'h0000_0007);
    chk("pc_inc", o_pc, p + 10'h001);
    mv(core_pkg::dest_acc, 8'h80);
    do_op(core_pkg::rot_left_op, core_pkg::dest_acc, 8'h80, 10'h000, 3'h0);
    chk("rot_c", o_flags[2], 32'h0000_0001);
    mv(core_pkg::dest_acc, 8'h05);
    do_op(core_pkg::jump_op, core_pkg::dest_acc, 8'h00, 10'h2FE, 3'h0);
    chk("jump", o_pc, 32'h0000_02FE);
    do_op(core_pkg::add_op, core_pkg::dest_pcl, 8'h05, 10'h000, 3'h0);
    chk("pcl_carry", o_pc, 32'h0000_0303);
    do_op(core_pkg::sub_op, core_pkg::dest_pcl, 8'h05, 10'h000, 3'h0);
    chk("pcl_borrow", o_pc, 32'h0000_03FE);
    chk("sub_c", o_flags[2], 32'h0000_0000);
    mv(core_pkg::dest_acc, 8'h28);
    mv(core_pkg::dest_pcl, 8'h28);
    chk("pcl_move", o_pc, 32'h0000_0328);
    do_op(core_pkg::call_op, core_pkg::dest_acc, 8'h00, 10'h1FF, 3'h0);
    chk("call", o_pc, 32'h0000_01FF);
    do_op(core_pkg::nop_op, core_pkg::dest_acc, 8'h00, 10'h000, 3'h0);
    chk("nop_pc", o_pc, 32'h0000_0200);
    do_op(core_pkg::jump_op, core_pkg::dest_acc, 8'h00, 10'h0FF, 3'h0);
    do_op(core_pkg::add_carry_op, core_pkg::dest_pcl, 8'h00, 10'h000, 3'h0);
    chk("adc_pcl", o_pc, 32'h0000_0127);
    do_op(core_pkg::add_carry_op, core_pkg::dest_pcl, 8'h00, 10'h000, 3'h0);
    chk("adc_cin", o_pc, 32'h0000_0150);
    do_op(core_pkg::jump_op, core_pkg::dest_acc, 8'h00, 10'h2E0, 3'h0);
    do_op(core_pkg::bank0_add_op, core_pkg::dest_pcl, 8'h00, 10'h000, 3'h0);
    chk("bank0_add_op_pcl", o_pc, 32'h0000_0308);
    mv(core_pkg::dest_acc, 8'h01);
    do_op(core_pkg::rot_right_op, core_pkg::dest_acc, 8'h00, 10'h000, 3'h0);
    chk("rotr", {o_flags[2], o_acc}, 32'h0000_0180);
    do_op(core_pkg::and_op, core_pkg::dest_acc, 8'h7F, 10'h000, 3'h0);
    chk("and_z", {o_flags[0], o_acc}, 32'h0000_0100);
    do_op(core_pkg::or_op, core_pkg::dest_acc, 8'h0F, 10'h000, 3'h0);
    chk("or_z", {o_flags[0], o_acc}, 32'h0000_000F);
    do_op(core_pkg::xor_op, core_pkg::dest_acc, 8'h0F, 10'h000, 3'h0);
    chk("xor_z", {o_flags[0], o_acc}, 32'h0000_0100);
    $display("test arithmetic done");

    do_skip(core_pkg::compare_skip_op, 8'h12, 3'h0, 1'b1);
    do_skip(core_pkg::compare_skip_op, 8'h13, 3'h0, 1'b0);
    do_skip(core_pkg::increment_to_acc_skip_op, 8'hFF, 3'h0, 1'b1);
    do_skip(core_pkg::increment_to_acc_skip_op, 8'hFE, 3'h0, 1'b0);
    do_skip(core_pkg::increment_mem_skip_op, 8'hFF, 3'h0, 1'b1);
    do_skip(core_pkg::increment_mem_skip_op, 8'h00, 3'h0, 1'b0);
    do_skip(core_pkg::decrement_to_acc_skip_op, 8'h01, 3'h0, 1'b1);
    do_skip(core_pkg::decrement_to_acc_skip_op, 8'h02, 3'h0, 1'b0);
    do_skip(core_pkg::decrement_mem_skip_op, 8'h01, 3'h0, 1'b1);
    do_skip(core_pkg::decrement_mem_skip_op, 8'h00, 3'h0, 1'b0);
    do_skip(core_pkg::bit_clear_skip_op, 8'hF7, 3'h3, 1'b1);
    do_skip(core_pkg::bit_clear_skip_op, 8'h08, 3'h3, 1'b0);
    do_skip(core_pkg::bit_set_skip_op, 8'h08, 3'h3, 1'b1);
    do_skip(core_pkg::bit_set_skip_op, 8'hF7, 3'h3, 1'b0);
    do_skip(core_pkg::bank0_bit_clear_skip_op, 8'hF7, 3'h3, 1'b1);
    do_skip(core_pkg::bank0_bit_set_skip_op, 8'hF7, 3'h3, 1'b0);
    $display("test skips done");

    mv(core_pkg::dest_acc, 8'h5A);
    fl = o_flags;
    do_op(core_pkg::push_op, core_pkg::dest_acc, 8'h00, 10'h000, 3'h0);
    do_op(core_pkg::add_op, core_pkg::dest_acc, 8'hA6, 10'h000, 3'h0);
    do_op(core_pkg::pop_op, core_pkg::dest_acc, 8'h00, 10'h000, 3'h0);
    chk("pop_acc", o_acc, 32'h0000_005A);
    chk("pop_flags", o_flags, fl);
    do_op(core_pkg::interrupt_entry_op, core_pkg::dest_acc, 8'h00, 10'h010, 3'h0);
    chk("irq_acc", o_acc, 32'h0000_005A);
    chk("irq_flags", o_flags, fl);
    chk("irq_pc", o_pc, 32'h0000_0010);
    do_op(core_pkg::interrupt_return_op, core_pkg::dest_acc, 8'h00, 10'h123, 3'h0);
    chk("ret_pc", o_pc, 32'h0000_0123);
    do_op(core_pkg::bank0_move_op, core_pkg::dest_mem, 8'h77, 10'h000, 3'h0);
    chk("bank0_move_op_we", o_mem_we, 32'h0000_0001);
    chk("bank0_move_op_acc", o_acc, 32'h0000_005A);
    chk("bank0_move_op_data", o_mem_data, 32'h0000_005A);
    $display("test save and restore done");
    rst_cycle(2'h2);
    rst_cycle(2'h0);
    $display("test reset cause done");
    report_and_stop();
  end
endmodule : acc_flags_program_counter_test
